// ===== common/pmms_pkg.sv
// Constants, mode type and helpers for the per-port media mode select block
// Operation
// - Select high sets status, forces fiber mode
// - Fiber duplex comes from fiber duplex pin; fiber chosen by the config pins takes duplex_pin instead
// - Select low clears the media status bit
// - Select low: global config pins choose mode
// - Config pins apply to all ports together
// - Fiber mode remaps network pins to fiber
// - Stacked variant: fiber only on ports 1, 3
// - Status bit is bit 2, register 19
package pmms_pkg;

   // Port count and config pin width
   localparam int PMMS_PORTS = 4;
   localparam int PMMS_CFG_W = 3;
   localparam int PMMS_ADDR_W = 12;
   localparam int PMMS_SYNC_STAGES = 2;

   // Operating modes of one port
   typedef enum logic [1:0] {
      PMMS_MODE_10T = 2'b00,
      PMMS_MODE_TX = 2'b01,
      PMMS_MODE_FX = 2'b10
   } pmms_mode_type;

   // Config pin codes and their modes
   localparam logic [2:0] PMMS_CFG_10T_A = 3'h0;
   localparam logic [2:0] PMMS_CFG_10T_B = 3'h1;
   localparam logic [2:0] PMMS_CFG_TX_A = 3'h2;
   localparam logic [2:0] PMMS_CFG_TX_B = 3'h3;
   localparam logic [2:0] PMMS_CFG_FX = 3'h4;

   // Fiber capable port masks per variant
   localparam logic [3:0] PMMS_CAP_QUAD = 4'hf;
   localparam logic [3:0] PMMS_CAP_STACKED = 4'ha;

   // Register map: byte addresses
   localparam logic [11:0] PMMS_CTRL_ADDR = 12'h000;
   localparam logic [11:0] PMMS_STATUS_ADDR = 12'h004;
   localparam int PMMS_PORT_CFG_IDX = 19;
   localparam logic [7:0] PMMS_PORT_CFG_BYTE = 8'(PMMS_PORT_CFG_IDX * 4);
   localparam int PMMS_PORT_SHIFT = 8;

   // Field positions and reset values
   localparam int PMMS_MEDIA_BIT = 2;
   localparam int PMMS_CTRL_DRIVE_BIT = 0;
   localparam logic PMMS_CTRL_DRIVE_RST = 1'b1;
   localparam int PMMS_STAT_MODE_LSB = 4;
   localparam int PMMS_STAT_FDX_LSB = 12;

   // Mode chosen by the global config pins
   function automatic pmms_mode_type pmms_cfg_mode(input logic [2:0] cfg);
      case (cfg)
         PMMS_CFG_10T_A, PMMS_CFG_10T_B: pmms_cfg_mode = PMMS_MODE_10T;
         PMMS_CFG_TX_A, PMMS_CFG_TX_B: pmms_cfg_mode = PMMS_MODE_TX;
         PMMS_CFG_FX: pmms_cfg_mode = PMMS_MODE_FX;
         default: pmms_cfg_mode = PMMS_MODE_TX;
      endcase
   endfunction

endpackage

// ===== sim/pmms_partner.sv
// Far-side model: fiber transceiver loop and a twisted-pair far end
`timescale 1ns/1ps

module pmms_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Line side of the device
   input wire logic [3:0] fib_out,
   output logic [3:0] fib_in,
   output logic [3:0] tp_in
);
   // Optical module echoes what the device sends it
   assign fib_in = fib_out;

   // Far end pattern changes every cycle, so a stale path never passes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tp_in <= 4'h5;
      end else begin
         tp_in <= {tp_in[2:0], tp_in[3] ^ tp_in[2]};
      end
   end
endmodule // pmms_partner

// ===== sim/test_port_media_mode_select.sv
// Self-checking bench: quad and stacked variants against a reference model
`timescale 1ns/1ps

module test_port_media_mode_select
   import pmms_pkg::*;
;
   // Bench state
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, r_drv;
   logic duplex_pin, fiber_duplex_pin, scrambler_bypass_pin, autoneg_enable_pin;
   logic [2:0] cfg_pins;
   logic [3:0] msi, line_tx, tp_in, fib_in, r_s1, r_s2;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [35:0] e_a, e_b, g_a, g_b;
   logic err;
   int mismatches, tests_run, cycles;

   // Design outputs of both variants
   logic [7:0] port_mode, pm_b;
   logic [3:0] port_full_duplex, media_status, tp_out, fib_out, line_rx, scrambler_bypass;
   logic [3:0] autoneg_enable, fd_b, ms_b, to_b, fo_b, rx_b, sb_b, an_b;
   assign g_a = {port_mode, port_full_duplex, media_status, tp_out, fib_out, line_rx,
      scrambler_bypass, autoneg_enable};
   assign g_b = {pm_b, fd_b, ms_b, to_b, fo_b, rx_b, sb_b, an_b};

   // Quad variant, all ports fiber capable
   pmms_top #(.NUM_PORTS(4), .STACKED(1'b0)) DUT (.clk, .rstn, .media_select_input(msi),
      .cfg_pins, .duplex_pin, .fiber_duplex_pin, .scrambler_bypass_pin, .autoneg_enable_pin,
      .port_mode, .port_full_duplex, .scrambler_bypass, .autoneg_enable, .media_status,
      .line_tx, .line_rx, .tp_in, .fib_in, .tp_out, .fib_out, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr);

   // Stacked variant shares every input; its bus answers are not used
   pmms_top #(.NUM_PORTS(4), .STACKED(1'b1)) DUT_B (.clk, .rstn, .media_select_input(msi),
      .cfg_pins, .duplex_pin, .fiber_duplex_pin, .scrambler_bypass_pin, .autoneg_enable_pin,
      .port_mode(pm_b), .port_full_duplex(fd_b), .scrambler_bypass(sb_b),
      .autoneg_enable(an_b), .media_status(ms_b), .line_tx, .line_rx(rx_b), .tp_in, .fib_in,
      .tp_out(to_b), .fib_out(fo_b), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata(), .pready(), .pslverr());

   // Far side of the quad device
   pmms_partner partner (.clk, .rstn, .fib_out, .fib_in, .tp_in);

   // Expected outputs one edge ahead, for a given fiber capable mask
   function automatic logic [35:0] model(input logic [3:0] cap);
      logic [7:0] m;
      logic [3:0] fd, ms, to, fo, rx;
      logic fx;
      for (int p = 0; p < 4; p++) begin
         ms[p] = r_s2[p] & cap[p];
         fx = ms[p] | ((cfg_pins == 3'h4) & cap[p]);
         m[2*p+:2] = fx ? PMMS_MODE_FX : (cfg_pins < 3'h2) ? PMMS_MODE_10T : PMMS_MODE_TX;
         fd[p] = ms[p] ? fiber_duplex_pin : duplex_pin;
         to[p] = ~fx & r_drv & line_tx[p];
         fo[p] = fx & r_drv & line_tx[p];
         rx[p] = fx ? fib_in[p] : tp_in[p];
      end
      return {m, fd, ms, to, fo, rx, {4{scrambler_bypass_pin}}, {4{autoneg_enable_pin}}};
   endfunction

   // Reference pipeline: two sync stages, then the output flop
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_s1 <= 4'h0;
         r_s2 <= 4'h0;
         r_drv <= PMMS_CTRL_DRIVE_RST;
         e_a <= 36'h0;
         e_b <= 36'h0;
      end else begin
         e_a <= model(PMMS_CAP_QUAD);
         e_b <= model(PMMS_CAP_STACKED);
         r_s2 <= r_s1;
         r_s1 <= msi;
         // Drive enable follows a completed write to the control word
         if (psel && penable && pready && pwrite && paddr == PMMS_CTRL_ADDR) begin
            r_drv <= pwdata[PMMS_CTRL_DRIVE_BIT];
         end
      end
   end

   // Compare on the falling edge, where outputs have settled
   always @(negedge clk) begin
      if (rstn) begin
         check("mode", e_a & 36'hff0000000, g_a & 36'hff0000000);
         check("duplex", e_a & 36'h00f000000, g_a & 36'h00f000000);
         check("media", e_a & 36'h000f00000, g_a & 36'h000f00000);
         check("route", e_a & 36'h0000fff00, g_a & 36'h0000fff00);
         check("global", e_a & 36'h0000000ff, g_a & 36'h0000000ff);
         check("stacked", e_b, g_b);
      end
   end

   task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; waits for pready, only the hang guard ends a stuck wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'h38ba));
      {rstn, psel, penable, pwrite, paddr, pwdata, cfg_pins, msi, line_tx} = '0;
      {duplex_pin, fiber_duplex_pin, scrambler_bypass_pin, autoneg_enable_pin} = 4'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, PMMS_CTRL_ADDR, 32'h0);
      check("ctrl_reset", 36'h1, 36'(q));
      for (int it = 0; it < 40; it++) begin
         // Strap: corners on passes 1 to 3, otherwise random; held while pins move
         @(posedge clk);
         msi <= it == 1 ? 4'hf : it == 2 ? 4'h5 : it == 3 ? 4'ha : 4'($urandom);
         repeat (12) begin
            @(posedge clk);
            cfg_pins <= 3'($urandom);
            {duplex_pin, fiber_duplex_pin, scrambler_bypass_pin, autoneg_enable_pin} <= 4'($urandom);
            line_tx <= 4'($urandom);
         end
         if (it == 10) apb(1'b1, PMMS_STATUS_ADDR, 32'hffffffff);
         if (it == 10) check("ro_err", 36'h0, 36'(err));
         if (it == 20) apb(1'b1, PMMS_CTRL_ADDR, 32'h0);
         if (it == 30) apb(1'b1, PMMS_CTRL_ADDR, 32'h1);
         apb(1'b0, PMMS_STATUS_ADDR, 32'h0);
         check("status_reg", 36'({16'h0, e_a[27:24], e_a[35:28], e_a[23:20]}), 36'(q));
         apb(1'b0, 12'((it % 4) << PMMS_PORT_SHIFT) | 12'(PMMS_PORT_CFG_BYTE), 32'h0);
         check("port_cfg", 36'(e_a[20 + it % 4]) << 2, 36'(q));
      end
      // Unmapped write is refused and leaves the control word alone
      apb(1'b1, 12'h008, 32'h0);
      check("unmapped", 36'h1, 36'(err));
      apb(1'b0, PMMS_CTRL_ADDR, 32'h0);
      check("ctrl_kept", 36'h1, 36'(q));
      finish_test();
   end
endmodule // test_port_media_mode_select

// ===== verilog/pmms_top.sv
// Per-port media mode select, network pin routing and APB status registers
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module pmms_top
   import pmms_pkg::*;
#(
   parameter int NUM_PORTS = PMMS_PORTS,
   parameter bit STACKED = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Strap and global hardware configuration pins
   input wire logic [NUM_PORTS-1:0] media_select_input,
   input wire logic [PMMS_CFG_W-1:0] cfg_pins,
   input wire logic duplex_pin,
   input wire logic fiber_duplex_pin,
   input wire logic scrambler_bypass_pin,
   input wire logic autoneg_enable_pin,
   // Per-port result of the mode selection
   output logic [2*NUM_PORTS-1:0] port_mode,
   output logic [NUM_PORTS-1:0] port_full_duplex,
   output logic [NUM_PORTS-1:0] scrambler_bypass,
   output logic [NUM_PORTS-1:0] autoneg_enable,
   output logic [NUM_PORTS-1:0] media_status,
   // Network pin routing, one line bit per port
   input wire logic [NUM_PORTS-1:0] line_tx,
   output logic [NUM_PORTS-1:0] line_rx,
   input wire logic [NUM_PORTS-1:0] tp_in,
   input wire logic [NUM_PORTS-1:0] fib_in,
   output logic [NUM_PORTS-1:0] tp_out,
   output logic [NUM_PORTS-1:0] fib_out,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PMMS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Only the four-port layout is served by the map and masks
   if (NUM_PORTS != PMMS_PORTS) begin : g_bad_ports
      $error("pmms_top: NUM_PORTS must be 4");
   end

   // Ports that may run fiber in this variant
   localparam logic [3:0] CAP = STACKED ? PMMS_CAP_STACKED : PMMS_CAP_QUAD;

   // Synchroniser stages for the strap
   logic [NUM_PORTS-1:0] sel_s1; // First stage, read only by sel_s2
   logic [NUM_PORTS-1:0] sel_s2; // Stable strap level
   // Software drive enable for the line outputs
   logic ctrl_drive_en;
   // Next values of the mode outputs
   logic [NUM_PORTS-1:0] fiber_forced;
   logic [2*NUM_PORTS-1:0] next_mode;
   logic [NUM_PORTS-1:0] next_fdx;
   logic [NUM_PORTS-1:0] next_fiber;
   // APB decode
   logic setup;
   logic access_done;
   logic [31:0] next_rdata;
   logic next_err;
   logic [1:0] port_sel;

   // Strap is treated as static; two flops keep a slow edge from upsetting the mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_s1 <= '0;
         sel_s2 <= '0;
      end else begin
         sel_s1 <= media_select_input;
         sel_s2 <= sel_s1;
      end
   end

   // Per-port mode choice from the strap and the global pins
   always_comb begin
      pmms_mode_type cfg_m;
      cfg_m = pmms_cfg_mode(cfg_pins);
      fiber_forced = '0;
      next_mode = '0;
      next_fdx = '0;
      next_fiber = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         // Ports without fiber capability ignore their strap
         fiber_forced[p] = sel_s2[p] & CAP[p];
         if (fiber_forced[p]) begin
            // Strap high forces fiber operation
            next_mode[2*p +: 2] = PMMS_MODE_FX;
            next_fdx[p] = fiber_duplex_pin;
         end else if (cfg_m == PMMS_MODE_FX && !CAP[p]) begin
            // Twisted-pair only port falls back to 100 TX
            next_mode[2*p +: 2] = PMMS_MODE_TX;
            next_fdx[p] = duplex_pin;
         end else begin
            // Strap low leaves the mode to the global pins
            next_mode[2*p +: 2] = cfg_m;
            next_fdx[p] = duplex_pin;
         end
         next_fiber[p] = (next_mode[2*p +: 2] == PMMS_MODE_FX);
      end
   end

   // Mode outputs; all ports load the global pins on the same edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_mode <= '0;
         port_full_duplex <= '0;
         scrambler_bypass <= '0;
         autoneg_enable <= '0;
         media_status <= '0;
      end else begin
         port_mode <= next_mode;
         port_full_duplex <= next_fdx;
         scrambler_bypass <= {NUM_PORTS{scrambler_bypass_pin}};
         autoneg_enable <= {NUM_PORTS{autoneg_enable_pin}};
         media_status <= fiber_forced;
      end
   end

   // Network pin routing; registered, so data lags the line by one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tp_out <= '0;
         fib_out <= '0;
         line_rx <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (next_fiber[p]) begin
               // Fiber: transmit on fiber pair, receive from fiber pair
               tp_out[p] <= 1'b0;
               fib_out[p] <= line_tx[p] & ctrl_drive_en;
               line_rx[p] <= fib_in[p];
            end else begin
               // Twisted pair: the same pins act as TP lines
               tp_out[p] <= line_tx[p] & ctrl_drive_en;
               fib_out[p] <= 1'b0;
               line_rx[p] <= tp_in[p];
            end
         end
      end
   end

   // APB phases; pready rises in the access cycle, so every transfer has no wait
   assign setup = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign port_sel = paddr[PMMS_PORT_SHIFT +: 2];

   // Read mux and address check, evaluated in the setup cycle
   always_comb begin
      next_rdata = 32'h0;
      next_err = 1'b0;
      if (paddr == PMMS_CTRL_ADDR) begin
         next_rdata[PMMS_CTRL_DRIVE_BIT] = ctrl_drive_en;
      end else if (paddr == PMMS_STATUS_ADDR) begin
         // Strap result, modes and duplex of every port
         next_rdata[NUM_PORTS-1:0] = media_status;
         next_rdata[PMMS_STAT_MODE_LSB +: 2*NUM_PORTS] = port_mode;
         next_rdata[PMMS_STAT_FDX_LSB +: NUM_PORTS] = port_full_duplex;
      end else if (paddr[PMMS_PORT_SHIFT-1:0] == PMMS_PORT_CFG_BYTE &&
                   paddr[PMMS_ADDR_W-1:PMMS_PORT_SHIFT+2] == '0) begin
         // Port configuration register; only the media bit is modelled
         next_rdata[PMMS_MEDIA_BIT] = media_status[port_sel];
      end else begin
         // Unmapped address answers with an error
         next_err = 1'b1;
      end
   end

   // Bus answer flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0 : next_rdata;
         pslverr <= next_err;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Control register; writes to read-only registers are dropped silently
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_drive_en <= PMMS_CTRL_DRIVE_RST;
      end else if (access_done && pwrite && paddr == PMMS_CTRL_ADDR) begin
         ctrl_drive_en <= pwdata[PMMS_CTRL_DRIVE_BIT];
      end
   end

   // Strap held high or low long enough to pass the synchroniser
   sequence s_sel_high;
      media_select_input[1] [*3];
   endsequence

   sequence s_sel_low;
      !media_select_input[1] [*3];
   endsequence

   // A rising strap after a quiet low period
   sequence s_sel_rise;
      !media_select_input[1] [*3] ##1 media_select_input[1];
   endsequence

   // Setup cycle of a read of port 1 configuration
   sequence s_rd_port1;
      psel && !penable && !pwrite &&
      paddr == {4'h1, PMMS_PORT_CFG_BYTE};
   endsequence

   a_sel_high_fx: assert property (@(posedge clk) disable iff (!rstn)
      s_sel_high |=> media_status[1] && port_mode[3:2] == PMMS_MODE_FX)
      else $error("strap high did not force fiber on port 1");

   a_fx_duplex: assert property (@(posedge clk) disable iff (!rstn)
      media_status[1] |-> port_full_duplex[1] == $past(fiber_duplex_pin))
      else $error("fiber duplex not taken from fiber duplex pin");

   a_sel_low_clear: assert property (@(posedge clk) disable iff (!rstn)
      s_sel_low |=> !media_status[1])
      else $error("strap low did not clear the media bit");

   a_tp_cfg_mode: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn) && !media_status[1] |-> port_mode[3:2] == pmms_cfg_mode($past(cfg_pins)) &&
      port_full_duplex[1] == $past(duplex_pin))
      else $error("twisted pair port ignores the config pins");

   a_global_apply: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (&scrambler_bypass || !(|scrambler_bypass)) &&
      (&autoneg_enable || !(|autoneg_enable)) &&
      scrambler_bypass[0] == $past(scrambler_bypass_pin))
      else $error("global pins not applied to all ports at once");

   a_fx_route: assert property (@(posedge clk) disable iff (!rstn)
      port_mode[3:2] == PMMS_MODE_FX |-> !tp_out[1] &&
      line_rx[1] == $past(fib_in[1]) &&
      fib_out[1] == ($past(line_tx[1]) && $past(ctrl_drive_en)))
      else $error("fiber mode did not remap port 1 pins");

   a_stacked_tp: assert property (@(posedge clk) disable iff (!rstn)
      STACKED |-> !media_status[0] && !media_status[2] &&
      port_mode[1:0] != PMMS_MODE_FX && port_mode[5:4] != PMMS_MODE_FX)
      else $error("twisted-pair only port ran fiber");

   a_status_read: assert property (@(posedge clk) disable iff (!rstn)
      s_rd_port1 |=> pready && prdata[PMMS_MEDIA_BIT] == $past(media_status[1]) &&
      !pslverr)
      else $error("port config read lost the media bit");

   a_strap_sync: assert property (@(posedge clk) disable iff (!rstn)
      s_sel_rise |=> !media_status[1] ##1 !media_status[1] ##1 media_status[1])
      else $error("strap not delayed by the synchroniser");

endmodule // pmms_top
